/* verilog/fbp_pkg.sv */
`default_nettype none
package fbp_pkg;
    // register byte addresses
    localparam logic [8:0] REG_CTRL = 9'h000;
    localparam logic [8:0] REG_CFG = 9'h004;
    localparam logic [8:0] REG_ADDR = 9'h008;
    localparam logic [8:0] REG_DATA = 9'h00C;
    localparam logic [8:0] REG_COUNT = 9'h010;
    localparam logic [8:0] REG_STATUS = 9'h014;
    localparam logic [8:0] REG_RDATA = 9'h018;
    localparam int BUF_SEL_BIT = 8;
    localparam int BUF_DEPTH = 64;
    localparam logic [5:0] BUF_MAX_WORD = 6'h1F;
    localparam logic [5:0] BUF_MAX_BYTE = 6'h3F;
    // cfg fields and reset values
    localparam int CFG_WORD = 0;
    localparam int CFG_RST = 1;
    localparam int CFG_HV = 2;
    localparam logic CFG_WORD_RST = 1'b1;
    // status fields
    localparam int ST_BUSY = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_RDY = 4;
    // flash status bits
    localparam int FL_ABORT = 1;
    localparam int FL_TLIM = 5;
    localparam int FL_TOG = 6;
    // operations
    localparam logic [3:0] OP_PROG = 4'h1;
    localparam logic [3:0] OP_BUF = 4'h2;
    localparam logic [3:0] OP_ABRST = 4'h3;
    localparam logic [3:0] OP_RESET = 4'h4;
    localparam logic [3:0] OP_READ = 4'h5;
    localparam logic [3:0] OP_SUSP = 4'h6;
    localparam logic [3:0] OP_RESUME = 4'h7;
    // timing at 40 MHz
    localparam int CLK_MHZ = 40;
    localparam int T_WP_NS = 50;
    localparam int T_ACC_NS = 100;
    localparam logic [2:0] WP_CYC = 3'((T_WP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [2:0] ACC_CYC = 3'((T_ACC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [2:0] SYNC_CYC = 3'h2;

    typedef enum logic [4:0] {
        C_IDLE = 5'h01, C_SETUP = 5'h02, C_STROBE = 5'h04, C_HOLD = 5'h08, C_SYNC = 5'h10
    } fbp_cph_t;

    typedef struct packed {
        fbp_cph_t ph;
        logic wr;
        logic [2:0] cnt;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [22:0] addr;
        logic [15:0] dq;
        logic dq_oe;
        logic done;
        logic [15:0] rdata;
        logic [15:0] s1;
        logic [15:0] s2;
    } fbp_eng_t;

    typedef enum logic [9:0] {
        S_IDLE = 10'h001, S_UNL1 = 10'h002, S_UNL2 = 10'h004, S_CMD = 10'h008, S_CNT = 10'h010,
        S_LOAD = 10'h020, S_CONF = 10'h040, S_DATA = 10'h080, S_POLL = 10'h100, S_RD = 10'h200
    } fbp_st_t;

    typedef struct packed {
        fbp_st_t st;
        logic [3:0] op;
        logic pend;
        logic [5:0] idx;
        logic [22:0] addr;
        logic [15:0] wdata;
        logic [5:0] count;
        logic word_mode;
        logic flash_rst_n;
        logic hv;
        logic busy;
        logic abort_seen;
        logic timeout_seen;
        logic refused;
        logic have_prev;
        logic prev_tog;
        logic [15:0] rdata;
        logic [31:0] rd_out;
        logic rb1;
        logic rb2;
    } fbp_top_t;
endpackage : fbp_pkg
`default_nettype wire

/* verilog/fbp_cyc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fbp_cyc_if;
    logic start;
    logic wr;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport ctl (output start, wr, addr, wdata, input done, rdata);
    modport eng (input start, wr, addr, wdata, output done, rdata);
endinterface : fbp_cyc_if
`default_nettype wire

/* verilog/fbp_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_cycle
    import fbp_pkg::*;
(
    input wire logic sys_clk_i,       // 40 MHz clock
    input wire logic rst_i,           // sync reset
    fbp_cyc_if.eng cyc,               // cycle request
    input wire logic [15:0] dq_i,     // data pins in
    output logic [22:0] addr_o,       // address pins
    output logic [15:0] dq_o,         // data pins out
    output logic dq_oe_o,             // data drive enable
    output logic ce_n_o,              // chip select
    output logic we_n_o,              // write strobe
    output logic oe_n_o               // output enable
);
    fbp_eng_t q, n;

    always_comb begin
        n = q;
        n.done = 1'b0;
        n.s1 = dq_i;
        n.s2 = q.s1;
        unique case (q.ph)
            C_IDLE: begin
                if (cyc.start) begin
                    n.wr = cyc.wr;
                    n.addr = cyc.addr;
                    n.dq = cyc.wdata;
                    n.ce_n = 1'b0;
                    n.oe_n = cyc.wr;
                    n.dq_oe = cyc.wr;
                    n.cnt = '0;
                    n.ph = C_SETUP;
                end
            end
            C_SETUP: begin
                n.ph = C_STROBE;
                // write only with ce low, oe high
                n.we_n = !q.wr;
            end
            C_STROBE: begin
                n.cnt = q.cnt + 3'h1;
                if (q.cnt == (q.wr ? WP_CYC : ACC_CYC) - 3'h1) begin
                    n.cnt = '0;
                    n.we_n = 1'b1;
                    n.ph = q.wr ? C_HOLD : C_SYNC;
                end
            end
            C_HOLD: begin
                n.ce_n = 1'b1;
                n.dq_oe = 1'b0;
                n.done = 1'b1;
                n.ph = C_IDLE;
            end
            C_SYNC: begin
                n.cnt = q.cnt + 3'h1;
                if (q.cnt == SYNC_CYC - 3'h1) begin
                    n.rdata = q.s2;
                    n.ce_n = 1'b1;
                    n.oe_n = 1'b1;
                    n.done = 1'b1;
                    n.ph = C_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.ph <= C_IDLE;
            q.ce_n <= 1'b1;
            q.we_n <= 1'b1;
            q.oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign cyc.done = q.done;
    assign cyc.rdata = q.rdata;
    assign addr_o = q.addr;
    assign dq_o = q.dq;
    assign dq_oe_o = q.dq_oe;
    assign ce_n_o = q.ce_n;
    assign we_n_o = q.we_n;
    assign oe_n_o = q.oe_n;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_wr_combo;
        !q.we_n |-> !q.ce_n && q.oe_n && q.dq_oe;
    endproperty
    a_wr_combo: assert property (p_wr_combo) else $error("write strobe without valid ce/oe");

    property p_we_width;
        $fell(q.we_n) |-> !q.we_n [*2] ##1 q.we_n ##1 q.ce_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

    c_write: cover property ($rose(q.done) && q.wr);
    c_read: cover property ($rose(q.done) && !q.wr);
endmodule : fbp_cycle
`default_nettype wire

/* verilog/fbp_top.sv */
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fbp_top
    import fbp_pkg::*;
#(
    parameter logic [22:0] UNLOCK_ADDR1 = 23'h000555,
    parameter logic [15:0] UNLOCK_DATA1 = 16'h00AA,
    parameter logic [22:0] UNLOCK_ADDR2 = 23'h0002AA,
    parameter logic [15:0] UNLOCK_DATA2 = 16'h0055,
    parameter logic [15:0] CMD_BUF_LOAD = 16'h0025,
    parameter logic [15:0] CMD_CONFIRM = 16'h0029,
    parameter logic [15:0] CMD_PROG = 16'h00A0,
    parameter logic [15:0] CMD_RESET = 16'h00F0,
    parameter logic [15:0] CMD_SUSPEND = 16'h00B0,
    parameter logic [15:0] CMD_RESUME = 16'h0030
) (
    input wire logic sys_clk_i,            // 40 MHz clock
    input wire logic rst_i,                // sync reset
    input wire logic [8:0] reg_addr_i,     // register address
    input wire logic [31:0] reg_wdata_i,   // register write data
    input wire logic reg_wr_i,             // write strobe
    input wire logic reg_rd_i,             // read strobe
    output logic [31:0] reg_rdata_o,       // read data, next cycle
    output logic [22:0] flash_addr_o,      // address pins
    output logic [15:0] flash_dq_o,        // data pins out
    output logic flash_dq_oe_o,            // data drive enable
    input wire logic [15:0] flash_dq_i,    // data pins in
    output logic flash_ce_n_o,             // chip select
    output logic flash_we_n_o,             // write strobe
    output logic flash_oe_n_o,             // output enable
    output logic flash_reset_n_o,          // hardware reset
    output logic flash_word_mode_o,        // byte select, high = word
    output logic autoselect_hv_addr_pin_o, // raise autoselect pin to hv
    input wire logic ready_busy_n_i        // ready/busy pin
);
    fbp_top_t q, n;
    logic [15:0] buf_mem [BUF_DEPTH];
    fbp_cyc_if cyc ();

    function automatic logic [15:0] cmd_code(input logic [3:0] op);
        unique case (op)
            OP_PROG: cmd_code = CMD_PROG;
            OP_BUF: cmd_code = CMD_BUF_LOAD;
            OP_SUSP: cmd_code = CMD_SUSPEND;
            OP_RESUME: cmd_code = CMD_RESUME;
            default: cmd_code = CMD_RESET;
        endcase
    endfunction

    function automatic logic starts_unlocked(input logic [3:0] op);
        starts_unlocked = (op == OP_PROG) || (op == OP_BUF) || (op == OP_ABRST);
    endfunction

    logic [15:0] bword;
    logic [5:0] cap;
    logic [3:0] new_op;
    logic st_tog;
    assign bword = buf_mem[q.idx];
    assign cap = q.word_mode ? BUF_MAX_WORD : BUF_MAX_BYTE;
    assign new_op = reg_wdata_i[3:0];
    assign st_tog = cyc.rdata[FL_TOG];
    assign cyc.start = (q.st != S_IDLE) && !q.pend;

    // cycle address and data per state
    always_comb begin
        cyc.wr = 1'b1;
        cyc.addr = q.addr;
        cyc.wdata = q.wdata;
        unique case (q.st)
            S_UNL1: begin
                cyc.addr = UNLOCK_ADDR1;
                cyc.wdata = UNLOCK_DATA1;
            end
            S_UNL2: begin
                cyc.addr = UNLOCK_ADDR2;
                cyc.wdata = UNLOCK_DATA2;
            end
            S_CMD: begin
                cyc.addr = (q.op == OP_BUF || q.op == OP_RESET) ? q.addr : UNLOCK_ADDR1;
                cyc.wdata = cmd_code(q.op);
            end
            S_CNT: cyc.wdata = {10'h000, q.count};
            S_LOAD: begin
                // byte mode puts lowest address on dq15
                cyc.addr = q.word_mode ? {q.addr[22:5], q.idx[4:0]} : {q.addr[22:5], q.idx[5:1]};
                cyc.wdata = q.word_mode ? bword : {q.idx[0], 7'h00, bword[7:0]};
            end
            S_CONF: cyc.wdata = CMD_CONFIRM;
            S_POLL, S_RD: cyc.wr = 1'b0;
            default: cyc.wr = 1'b1;
        endcase
    end

    always_comb begin
        n = q;
        n.rb1 = ready_busy_n_i;
        n.rb2 = q.rb1;
        n.rd_out = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CFG: n.rd_out = {29'h0, q.hv, !q.flash_rst_n, q.word_mode};
                REG_ADDR: n.rd_out = {9'h000, q.addr};
                REG_DATA: n.rd_out = {16'h0000, q.wdata};
                REG_COUNT: n.rd_out = {26'h0, q.count};
                REG_STATUS: n.rd_out = {27'h0, q.rb2, q.refused, q.timeout_seen, q.abort_seen, q.busy};
                REG_RDATA: n.rd_out = {16'h0000, q.rdata};
                default: n.rd_out = '0;
            endcase
        end
        if (reg_wr_i) begin
            if (reg_addr_i == REG_CFG) begin
                n.word_mode = reg_wdata_i[CFG_WORD];
                n.flash_rst_n = !reg_wdata_i[CFG_RST];
                n.hv = reg_wdata_i[CFG_HV];
            end
            if (!q.busy) begin
                if (reg_addr_i == REG_ADDR) n.addr = reg_wdata_i[22:0];
                if (reg_addr_i == REG_DATA) n.wdata = reg_wdata_i[15:0];
                if (reg_addr_i == REG_COUNT) n.count = reg_wdata_i[5:0];
            end
            if (reg_addr_i == REG_CTRL) begin
                if (q.busy || (new_op == OP_BUF && q.count > cap)) begin
                    n.refused = 1'b1;
                end else if (new_op >= OP_PROG && new_op <= OP_RESUME) begin
                    n.op = new_op;
                    n.busy = 1'b1;
                    n.abort_seen = 1'b0;
                    n.timeout_seen = 1'b0;
                    n.refused = 1'b0;
                    n.st = starts_unlocked(new_op) ? S_UNL1 : (new_op == OP_READ ? S_RD : S_CMD);
                end
            end
        end
        if (cyc.start) n.pend = 1'b1;
        if (cyc.done) begin
            n.pend = 1'b0;
            unique case (q.st)
                S_UNL1: n.st = S_UNL2;
                S_UNL2: n.st = S_CMD;
                S_CMD: begin
                    n.st = (q.op == OP_PROG) ? S_DATA : (q.op == OP_BUF ? S_CNT : S_IDLE);
                    n.busy = (q.op == OP_PROG) || (q.op == OP_BUF);
                    n.idx = '0;
                end
                S_CNT: n.st = S_LOAD;
                S_LOAD: begin
                    if (q.idx == q.count) n.st = S_CONF;
                    else n.idx = q.idx + 6'h01;
                end
                S_CONF, S_DATA: begin
                    n.st = S_POLL;
                    n.have_prev = 1'b0;
                end
                S_POLL: begin
                    n.rdata = cyc.rdata;
                    n.have_prev = 1'b1;
                    n.prev_tog = st_tog;
                    if (q.have_prev && st_tog == q.prev_tog) begin
                        n.st = S_IDLE;
                        n.busy = 1'b0;
                    // flag must stand in both toggling reads, array data may follow the last status
                    end else if (q.have_prev && cyc.rdata[FL_ABORT] && q.rdata[FL_ABORT] && q.op == OP_BUF) begin
                        n.abort_seen = 1'b1;
                        n.op = OP_ABRST;
                        n.st = S_UNL1;
                    end else if (q.have_prev && cyc.rdata[FL_TLIM] && q.rdata[FL_TLIM]) begin
                        n.timeout_seen = 1'b1;
                        n.op = OP_RESET;
                        n.st = S_CMD;
                    end
                end
                S_RD: begin
                    n.rdata = cyc.rdata;
                    n.st = S_IDLE;
                    n.busy = 1'b0;
                end
                default: n.st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= S_IDLE;
            q.word_mode <= CFG_WORD_RST;
            q.flash_rst_n <= 1'b1;
            q.rb1 <= 1'b1;
            q.rb2 <= 1'b1;
        end else begin
            q <= n;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reg_wr_i && reg_addr_i[BUF_SEL_BIT]) begin
            buf_mem[reg_addr_i[7:2]] <= reg_wdata_i[15:0];
        end
    end

    fbp_cycle u_cycle (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .cyc(cyc.eng),
        .dq_i(flash_dq_i),
        .addr_o(flash_addr_o),
        .dq_o(flash_dq_o),
        .dq_oe_o(flash_dq_oe_o),
        .ce_n_o(flash_ce_n_o),
        .we_n_o(flash_we_n_o),
        .oe_n_o(flash_oe_n_o)
    );

    assign reg_rdata_o = q.rd_out;
    assign flash_reset_n_o = q.flash_rst_n;
    assign flash_word_mode_o = q.word_mode;
    assign autoselect_hv_addr_pin_o = q.hv;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_count_after_load;
        $rose(q.st == S_CNT) |-> $past(q.st == S_CMD) && q.op == OP_BUF;
    endproperty
    a_count_after_load: assert property (p_count_after_load) else $error("count cycle out of order");

    property p_confirm_after_loads;
        $rose(q.st == S_CONF) |-> q.idx == q.count && $past(q.st == S_LOAD);
    endproperty
    a_confirm_after_loads: assert property (p_confirm_after_loads) else $error("confirm before all loads");

    property p_abort_reset;
        $rose(q.abort_seen) |-> q.st == S_UNL1 && q.op == OP_ABRST ##[1:40] q.st == S_CMD;
    endproperty
    a_abort_reset: assert property (p_abort_reset) else $error("no abort reset after abort");

    property p_timeout_reset;
        $rose(q.timeout_seen) |-> q.st == S_CMD && q.op == OP_RESET ##[1:20] !q.busy;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("no reset after time limit");

    property p_single_prog;
        $rose(q.st == S_DATA) |-> $past(q.st == S_CMD) && q.op == OP_PROG;
    endproperty
    a_single_prog: assert property (p_single_prog) else $error("program data without command");

    property p_cmd_code;
        cyc.start && q.st == S_CMD && q.op == OP_PROG |-> cyc.wdata == CMD_PROG && cyc.addr == UNLOCK_ADDR1;
    endproperty
    a_cmd_code: assert property (p_cmd_code) else $error("wrong program command code");

    property p_wr_only_cycle;
        !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o;
    endproperty
    a_wr_only_cycle: assert property (p_wr_only_cycle) else $error("invalid write pin combination");

    c_buf_done: cover property ($fell(q.busy) && q.op == OP_BUF);
    c_abort: cover property ($rose(q.abort_seen));
    c_timeout: cover property ($rose(q.timeout_seen));
endmodule : fbp_top
`default_nettype wire

/* test/fbp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_model #(
    parameter logic [7:0] MFR_ID = 8'h5A,  // arbitrary value
    parameter logic [7:0] SEC_CODE = 8'h19
) (
    input wire logic [22:0] addr_i,    // address pins
    input wire logic [15:0] dq_i,      // data from host
    input wire logic ce_n_i,           // chip select
    input wire logic we_n_i,           // write strobe
    input wire logic oe_n_i,           // output enable
    input wire logic reset_n_i,        // hardware reset
    input wire logic hv_i,             // autoselect pin at hv
    input wire logic force_abort_i,    // fail next confirm
    input wire logic force_tlim_i,     // next program times out
    output logic [15:0] dq_o,          // data to host
    output logic ready_busy_n_o        // ready/busy pin
);
    logic [15:0] mem [0:4095];
    logic [22:0] ba [0:31];
    logic [15:0] bd [0:31];
    logic [15:0] last_d = 16'hFFFF;
    logic [15:0] rel = 16'h5A5A;
    logic [10:0] sect = '0;
    logic [17:0] page = '0;
    logic busy = 1'b0;
    logic aborted = 1'b0;
    logic tlim = 1'b0;
    logic tog = 1'b0;
    realtime t_fall = 0.0;
    int st = 0;
    int left = 0;
    int n = 0;
    int k = 0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // released bus changes every cycle
    always #25 rel = ~rel;
    assign ready_busy_n_o = ~busy;
    always @(negedge we_n_i) t_fall = $realtime;
    always @(posedge we_n_i, negedge oe_n_i, negedge reset_n_i) begin
        // let ce and oe, launched by one edge, both settle
        #1;
        if (!reset_n_i) begin
            busy = 1'b0;
            aborted = 1'b0;
            tlim = 1'b0;
            st = 0;
        end else if (!ce_n_i && !oe_n_i && we_n_i) begin
            if (busy || aborted) tog = ~tog;
            if (busy && !tlim) begin
                left = left - 1;
                if (left == 0) busy = 1'b0;
            end
        // write needs ce, we low, oe high
        end else if (!ce_n_i && oe_n_i && $realtime - t_fall >= 5.0) begin
            last_d = dq_i;
            if (busy) begin
                if (tlim && dq_i == 16'h00F0) begin
                    busy = 1'b0;
                    tlim = 1'b0;
                end
            end else begin
                case (st)
                    0: st = (addr_i == 23'h000555 && dq_i == 16'h00AA) ? 1 : 0;
                    1: st = (addr_i == 23'h0002AA && dq_i == 16'h0055) ? 2 : 0;
                    2: begin
                        st = 0;
                        if (dq_i == 16'h00F0) aborted = 1'b0;
                        if (!aborted && dq_i == 16'h0025) begin
                            st = 3;
                            sect = addr_i[22:12];
                        end
                        if (!aborted && dq_i == 16'h00A0) st = 6;
                    end
                    3: begin
                        n = int'(dq_i) + 1;
                        k = 0;
                        st = 4;
                        if (dq_i > 16'h001F) begin
                            aborted = 1'b1;
                            st = 0;
                        end
                    end
                    4: begin
                        if (k == 0) page = addr_i[22:5];
                        if (addr_i[22:12] != sect || addr_i[22:5] != page) begin
                            aborted = 1'b1;
                            st = 0;
                        end else begin
                            ba[k] = addr_i;
                            bd[k] = dq_i;
                            k++;
                            if (k == n) st = 5;
                        end
                    end
                    5: begin
                        st = 7;
                        if (dq_i != 16'h0029 || force_abort_i) begin
                            aborted = 1'b1;
                            st = 0;
                        end else begin
                            for (int i = 0; i < n; i++) mem[ba[i][11:0]] &= bd[i];
                        end
                    end
                    6: begin
                        st = 7;
                        mem[addr_i[11:0]] &= dq_i;
                    end
                    default: st = 0;
                endcase
                if (st == 7) begin
                    st = 0;
                    busy = 1'b1;
                    tlim = force_tlim_i;
                    left = 3;
                end
            end
        end
    end
    always @* begin
        if (ce_n_i || oe_n_i) dq_o = rel;
        else if (busy || aborted) dq_o = {8'h00, ~last_d[7], tog, tlim, 3'b000, aborted, 1'b0};
        else if (hv_i) begin
            case ({addr_i[6], addr_i[3:0]})
                5'b00000: dq_o = {8'h00, MFR_ID};
                5'b00010: dq_o = {15'h0000, addr_i[12]};
                5'b00011: dq_o = {8'h00, SEC_CODE};
                default: dq_o = rel;
            endcase
        end else dq_o = mem[addr_i[11:0]];
    end
endmodule : fbp_flash_model
`default_nettype wire

/* test/fbp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_top_tb;
    import fbp_pkg::*;
    localparam logic [7:0] MFR = 8'h5A;  // arbitrary value
    localparam logic [7:0] SEC = 8'h19;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [8:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o, got;
    logic [22:0] fa, base;
    logic [15:0] fdo, fdi, v;
    logic foe, ce_n, we_n, oe_n, frst_n, fword, fhv, rbn;
    logic f_abort = 1'b0;
    logic f_tlim = 1'b0;
    logic chk = 1'b0;
    logic chk_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [15:0] d[32];
    logic [3:0] ops[4] = '{OP_SUSP, OP_RESUME, OP_RESET, OP_ABRST};
    int n_errors = 0;
    int check_count = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    fbp_top fbp_top_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flash_addr_o(fa),
        .flash_dq_o(fdo), .flash_dq_oe_o(foe), .flash_dq_i(fdi), .flash_ce_n_o(ce_n),
        .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_reset_n_o(frst_n),
        .flash_word_mode_o(fword), .autoselect_hv_addr_pin_o(fhv), .ready_busy_n_i(rbn)
    );
    fbp_flash_model #(.MFR_ID(MFR), .SEC_CODE(SEC)) fbp_flash_model_i (
        .addr_i(fa), .dq_i(fdo), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .reset_n_i(frst_n),
        .hv_i(fhv), .force_abort_i(f_abort), .force_tlim_i(f_tlim), .dq_o(fdi), .ready_busy_n_o(rbn)
    );
    task automatic results();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic wr(input logic [8:0] a, input logic [31:0] x);
        reg_addr_i <= a;
        reg_wdata_i <= x;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic c, input logic [31:0] e);
        if (c) exp_q.push_back(e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        chk <= c;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        chk <= 1'b0;
        #1 got = reg_rdata_o;
        @(posedge sys_clk_i);
    endtask : rd
    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000; i++) begin
            rd(REG_STATUS, 1'b0, '0);
            if (got[ST_BUSY] === 1'b0) break;
        end
        if (i == 3000) begin
            n_errors++;
            results();
        end
    endtask : wait_idle
    task automatic prog(input logic [22:0] a, input logic [15:0] x);
        wr(REG_ADDR, {9'h000, a});
        wr(REG_DATA, {16'h0000, x});
        wr(REG_CTRL, {28'h0000000, OP_PROG});
        wait_idle();
    endtask : prog
    task automatic readf(input logic [22:0] a, input logic [15:0] e);
        wr(REG_ADDR, {9'h000, a});
        wr(REG_CTRL, {28'h0000000, OP_READ});
        wait_idle();
        rd(REG_RDATA, 1'b1, {16'h0000, e});
    endtask : readf
    always @(posedge sys_clk_i) begin
        chk_d <= chk;
        if (chk_d) check("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
    end
    initial begin
        void'($urandom(32'h3C519553));
        repeat (3) @(posedge sys_clk_i);
        #1 check("pins", 32'h1F, {25'h0, fhv, foe, fword, frst_n, ce_n, we_n, oe_n});
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(REG_CFG, 1'b1, 32'h1);
        rd(9'h01C, 1'b1, 32'h0);
        v = 16'($urandom);
        prog(23'h000123, v);
        wr(REG_DATA, 32'h0F0F);
        wr(REG_CTRL, {28'h0000000, OP_PROG});
        wr(REG_CTRL, {28'h0000000, OP_READ});
        wait_idle();
        rd(REG_STATUS, 1'b1, 32'h18);
        readf(23'h000123, v & 16'h0F0F);
        base = 23'h000240;
        for (int i = 0; i < 32; i++) begin
            d[i] = 16'($urandom);
            wr(9'h100 + 9'(4 * i), {16'h0000, d[i]});
        end
        wr(REG_ADDR, {9'h000, base | 23'h7});
        wr(REG_COUNT, 32'h1F);
        wr(REG_CTRL, {28'h0000000, OP_BUF});
        wait_idle();
        rd(REG_STATUS, 1'b1, 32'h10);
        for (int i = 0; i < 32; i++) readf(base + 23'(i), d[i]);
        wr(REG_COUNT, 32'h20);
        wr(REG_CTRL, {28'h0000000, OP_BUF});
        rd(REG_STATUS, 1'b1, 32'h18);
        f_abort <= 1'b1;
        wr(REG_ADDR, 32'h300);
        wr(REG_COUNT, 32'h3);
        wr(REG_CTRL, {28'h0000000, OP_BUF});
        wait_idle();
        f_abort <= 1'b0;
        rd(REG_STATUS, 1'b1, 32'h12);
        readf(23'h000300, 16'hFFFF);
        f_tlim <= 1'b1;
        prog(23'h000400, v);
        f_tlim <= 1'b0;
        rd(REG_STATUS, 1'b1, 32'h14);
        readf(23'h000400, v);
        wr(9'h180, 32'h0);
        wr(REG_CFG, 32'h0);
        wr(REG_COUNT, 32'h20);
        wr(REG_CTRL, {28'h0000000, OP_BUF});
        wait_idle();
        rd(REG_STATUS, 1'b1, 32'h12);
        wr(REG_CFG, 32'h5);
        readf(23'h000000, {8'h00, MFR});
        readf(23'h001002, 16'h0001);
        readf(23'h000002, 16'h0000);
        readf(23'h000003, {8'h00, SEC});
        wr(REG_CFG, 32'h3);
        #1 check("reset pin", 32'h0, {31'h0, frst_n});
        @(posedge sys_clk_i);
        wr(REG_CFG, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(REG_CTRL, {28'h0000000, ops[i]});
            wait_idle();
        end
        readf(base, d[0]);
        results();
    end
endmodule : fbp_top_tb
`default_nettype wire
